// ===== rtl/pcc_map.vh
// offsets, field positions and reset values of the configuration block
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// byte offsets of the configuration words; 034h is not decoded and reads zero
`define PCC_OFF_IDENT       12'h000
`define PCC_OFF_CMDSTAT     12'h004
`define PCC_OFF_CAP_PTR     12'h034
`define PCC_OFF_EXTCAP      12'h100

// the same words as dword indices, as carried on the access port
`define PCC_IDX_IDENT       10'h000
`define PCC_IDX_CMDSTAT     10'h001
`define PCC_IDX_EXTCAP      10'h040

// command field positions (low half of the 04h word)
`define PCC_CMD_IO_EN       0
`define PCC_CMD_MEM_EN      1
`define PCC_CMD_PERR_RSP    6
`define PCC_CMD_SERR_EN     8
`define PCC_CMD_INTX_DIS    10
`define PCC_CMD_RW_MASK     16'h0543
`define PCC_CMD_RESET       16'h0000

// status field positions (upper half of the 04h word)
`define PCC_ST_INTX         19
`define PCC_ST_CAP_LIST     20
`define PCC_ST_SIG_TABORT   27
`define PCC_ST_SIG_SERR     30
`define PCC_ST_DET_PERR     31

// extended capability header at 100h
`define PCC_EXT_CAP_ID      16'h0001
`define PCC_EXT_CAP_VER     4'h1
`define PCC_EXT_NEXT_OFF    12'h000

// identification defaults (arbitrary neutral values)
`define PCC_MAKER_DFLT      16'hA5A5
`define PCC_PART_DFLT       16'h0001

`endif

// ===== rtl/pcc_w1c_flag.v
// one sticky status flag, set by hardware and cleared by writing one
module pcc_w1c_flag
(
    input  wire clk,
    input  wire rst,
    input  wire set_evt,
    input  wire clr_req,
    output reg  flag_r
);

    reg flag_nxt;

    ////////////////////////////////////////////////////////////////////////
    // the set is checked first so an event in the clearing cycle survives
    always @*
    begin
        flag_nxt = flag_r;
        if (set_evt)
        begin
            flag_nxt = 1'b1;
        end
        else if (clr_req)
        begin
            flag_nxt = 1'b0;                          // [R16]
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flag_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

endmodule // pcc_w1c_flag

// ===== rtl/pcc_cfg.v
// type 0 configuration header: identity, command, status, extended header
//
// Functional notes
// R1: first extended header at 100h, id 001h, next offset 000h.
// R2: read-only 16-bit maker identity, bits 15:0, EEPROM load may replace.
// R3: read-only 16-bit part identity, bits 31:16, EEPROM load may replace.
// R4: command bit 0, reset 0, gates response to I/O space accesses.
// R5: command bit 1, reset 0, gates response to memory space accesses.
// R6: legacy command bits 3,4,5,7,9 and status 21,23,26:25 read zero.
// R7: command bit 6 enables parity action; else only the parity flag.
// R8: command bit 8 enables reporting fatal and non-fatal errors upstream.
// R9: command bit 10 set suppresses INTx interrupt messages.
// R10: bus master enable and status bits 24,28,29 hardwired zero.
// R11: status bit 19 follows internally pending INTx, reset 0.
// R12: status bit 20 reads one, capability list exists.
// R13: status bit 27 set on completer abort, write one clears.
// R14: status bit 30 set on error message sent with enable, write one clears.
// R15: status bit 31 set on poisoned TLP received, write one clears.
// R16: write-one-to-clear bits clear on one, keep on zero.
// R17: writes to read-only, reserved and hardwired fields are ignored.
`include "pcc_map.vh"

module pcc_cfg
#(
    parameter [15:0] MAKER_IDENT_DFLT = `PCC_MAKER_DFLT,
    parameter [15:0] PART_IDENT_DFLT  = `PCC_PART_DFLT,
    parameter [3:0]  EXT_CAP_VERSION  = `PCC_EXT_CAP_VER
)
(
    input  wire        clk,
    input  wire        rst,
    // configuration access from the link layer
    input  wire        cfg_rd_en,
    input  wire        cfg_wr_en,
    input  wire [9:0]  cfg_dw_addr,
    input  wire [3:0]  cfg_byte_en,
    input  wire [31:0] cfg_wr_data,
    output reg  [31:0] cfg_rd_data_r,
    output reg         cfg_rd_valid_r,
    output reg         cfg_wr_done_r,
    // identity load from the serial EEPROM loader
    input  wire        id_load_en,
    input  wire [15:0] id_load_maker,
    input  wire [15:0] id_load_part,
    // space decode gating
    input  wire        io_req,
    input  wire        mem_req,
    output reg         io_accept_r,
    output reg         mem_accept_r,
    // error and event inputs from the transaction layer
    input  wire        cpl_abort_evt,
    input  wire        poisoned_tlp_evt,
    input  wire        nonfatal_err_evt,
    input  wire        fatal_err_evt,
    input  wire        err_msg_sent_evt,
    input  wire        intx_pending,
    // requests and enables toward the rest of the device
    output reg         parity_action_r,
    output reg         err_nonfatal_req_r,
    output reg         err_fatal_req_r,
    output reg         intx_msg_en_r,
    output reg  [15:0] command_r,
    output wire [15:0] status_flags_r
);

    ////////////////////////////////////////////////////////////////////////
    // storage and decode nets
    reg  [15:0] maker_ident_r;
    reg  [15:0] part_ident_r;
    reg  [15:0] command_nxt;
    reg         intx_status_r;
    reg  [31:0] rd_word;
    reg  [15:0] cmd_wmask;

    wire        hit_ident;
    wire        hit_cmdstat;
    wire        hit_extcap;
    wire        wr_cmdstat;
    wire        serr_en;
    wire        perr_rsp_en;
    wire        intx_dis;
    wire        io_en;
    wire        mem_en;
    wire        tabort_flag;
    wire        sig_serr_flag;
    wire        det_perr_flag;
    wire        clr_tabort;
    wire        clr_sig_serr;
    wire        clr_det_perr;
    wire        set_sig_serr;

    ////////////////////////////////////////////////////////////////////////
    // address decode and command field taps
    assign hit_ident   = (cfg_dw_addr == `PCC_IDX_IDENT);
    assign hit_cmdstat = (cfg_dw_addr == `PCC_IDX_CMDSTAT);
    assign hit_extcap  = (cfg_dw_addr == `PCC_IDX_EXTCAP);
    assign wr_cmdstat  = cfg_wr_en & hit_cmdstat;

    assign io_en       = command_r[`PCC_CMD_IO_EN];
    assign mem_en      = command_r[`PCC_CMD_MEM_EN];
    assign perr_rsp_en = command_r[`PCC_CMD_PERR_RSP];
    assign serr_en     = command_r[`PCC_CMD_SERR_EN];
    assign intx_dis    = command_r[`PCC_CMD_INTX_DIS];

    ////////////////////////////////////////////////////////////////////////
    // identity words
    // identity is not writable from the link; only the loader changes it
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            maker_ident_r <= MAKER_IDENT_DFLT;
            part_ident_r  <= PART_IDENT_DFLT;
        end
        else if (id_load_en)
        begin
            maker_ident_r <= id_load_maker;                   // [R2]
            part_ident_r  <= id_load_part;                    // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command register
    // only the five implemented bits are ever stored, so every hardwired
    // and reserved command bit stays zero whatever software writes
    // lane 2 carries no command bits, so its enable is never looked at
    always @*
    begin
        cmd_wmask   = {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}}
                      & `PCC_CMD_RW_MASK;                      // [R6] [R10]
        command_nxt = command_r;
        if (wr_cmdstat)
        begin
            command_nxt = (command_r & ~cmd_wmask)
                          | (cfg_wr_data[15:0] & cmd_wmask);   // [R17]
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            command_r <= `PCC_CMD_RESET;                       // [R4] [R5]
        end
        else
        begin
            command_r <= command_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags
    // clears only act on byte lane 3, where all three sticky bits live
    assign clr_tabort   = wr_cmdstat & cfg_byte_en[3]
                          & cfg_wr_data[`PCC_ST_SIG_TABORT];   // [R16]
    assign clr_sig_serr = wr_cmdstat & cfg_byte_en[3]
                          & cfg_wr_data[`PCC_ST_SIG_SERR];     // [R16]
    assign clr_det_perr = wr_cmdstat & cfg_byte_en[3]
                          & cfg_wr_data[`PCC_ST_DET_PERR];     // [R16]

    // an error message sent while reporting is off leaves the flag alone
    assign set_sig_serr = err_msg_sent_evt & serr_en;          // [R14]

    // one flag instance per sticky bit; a set beats a same-cycle clear
    pcc_w1c_flag u_flag_tabort
    (
        .clk     (clk),
        .rst     (rst),
        .set_evt (cpl_abort_evt),                              // [R13]
        .clr_req (clr_tabort),
        .flag_r  (tabort_flag)
    );

    pcc_w1c_flag u_flag_sig_serr
    (
        .clk     (clk),
        .rst     (rst),
        .set_evt (set_sig_serr),
        .clr_req (clr_sig_serr),
        .flag_r  (sig_serr_flag)
    );

    // poisoned data always marks the flag, independent of the enable
    pcc_w1c_flag u_flag_det_perr
    (
        .clk     (clk),
        .rst     (rst),
        .set_evt (poisoned_tlp_evt),                           // [R15] [R7]
        .clr_req (clr_det_perr),
        .flag_r  (det_perr_flag)
    );

    // pending interrupt is mirrored, not latched
    // it falls as soon as the source is served; there is nothing to clear
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            intx_status_r <= 1'b0;
        end
        else
        begin
            intx_status_r <= intx_pending;                     // [R11]
        end
    end

    // upper half of the 04h word, one field a line, top bit first
    assign status_flags_r = {det_perr_flag,        // 31    [R15]
                             sig_serr_flag,        // 30    [R14]
                             2'b00,                // 29:28 [R10]
                             tabort_flag,          // 27    [R13]
                             2'b00,                // 26:25 [R6]
                             1'b0,                 // 24    [R10]
                             1'b0,                 // 23    [R6]
                             1'b0,                 // 22 reserved
                             1'b0,                 // 21    [R6]
                             1'b1,                 // 20    [R12]
                             intx_status_r,        // 19    [R11]
                             3'b000};              // 18:16 reserved

    ////////////////////////////////////////////////////////////////////////
    // read decode
    // unmapped words read as zero so probing software sees no structure
    // a read beside a write in one cycle returns the word before the write
    always @*
    begin
        rd_word = 32'h0000_0000;
        if (hit_ident)
        begin
            rd_word = {part_ident_r, maker_ident_r};          // [R2] [R3]
        end
        else if (hit_cmdstat)
        begin
            rd_word = {status_flags_r, command_r};            // [R16]
        end
        else if (hit_extcap)
        begin
            rd_word = {`PCC_EXT_NEXT_OFF, EXT_CAP_VERSION,
                       `PCC_EXT_CAP_ID};                       // [R1]
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_rd_data_r  <= 32'h0000_0000;
            cfg_rd_valid_r <= 1'b0;
            cfg_wr_done_r  <= 1'b0;
        end
        else
        begin
            cfg_rd_valid_r <= cfg_rd_en;
            cfg_wr_done_r  <= cfg_wr_en;
            if (cfg_rd_en)
            begin
                cfg_rd_data_r <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // space decode gating
    // a refused access gets no accept pulse; the link layer then
    // answers it as unsupported, this block does not build that answer
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            io_accept_r  <= 1'b0;
            mem_accept_r <= 1'b0;
        end
        else
        begin
            io_accept_r  <= io_req & io_en;                    // [R4]
            mem_accept_r <= mem_req & mem_en;                  // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error reporting and interrupt messages
    // both severities share one enable; the severity is picked upstream
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            parity_action_r    <= 1'b0;
            err_nonfatal_req_r <= 1'b0;
            err_fatal_req_r    <= 1'b0;
            intx_msg_en_r      <= 1'b0;
        end
        else
        begin
            // with the enable clear the flag is all that happens
            parity_action_r    <= poisoned_tlp_evt & perr_rsp_en; // [R7]
            err_nonfatal_req_r <= nonfatal_err_evt & serr_en;     // [R8]
            err_fatal_req_r    <= fatal_err_evt & serr_en;        // [R8]
            // the status bit keeps showing the pending level while disabled
            intx_msg_en_r      <= intx_pending & ~intx_dis;       // [R9]
        end
    end

endmodule // pcc_cfg

// ===== tb/pcc_cfg_properties.sv
// concurrent checks on the ports of the configuration block
`include "pcc_map.vh"
module pcc_cfg_properties
#(
    parameter [3:0] EXT_CAP_VERSION = `PCC_EXT_CAP_VER
)
(
    input wire        clk,
    input wire        rst,
    input wire        cfg_rd_en,
    input wire        cfg_wr_en,
    input wire [9:0]  cfg_dw_addr,
    input wire [3:0]  cfg_byte_en,
    input wire [31:0] cfg_wr_data,
    input wire [31:0] cfg_rd_data_r,
    input wire        io_req,
    input wire        mem_req,
    input wire        io_accept_r,
    input wire        mem_accept_r,
    input wire        poisoned_tlp_evt,
    input wire        err_msg_sent_evt,
    input wire        intx_pending,
    input wire        parity_action_r,
    input wire [15:0] command_r,
    input wire [15:0] status_flags_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    a_ext_header:
    assert property (cfg_rd_en && cfg_dw_addr == `PCC_IDX_EXTCAP |=>
        cfg_rd_data_r == {`PCC_EXT_NEXT_OFF, EXT_CAP_VERSION,
        `PCC_EXT_CAP_ID}) else $error("ext header word wrong");
    a_io_gate:
    assert property (io_req |=> io_accept_r == $past(command_r[0]))
        else $error("io accept wrong");
    a_mem_gate:
    assert property (mem_req |=> mem_accept_r == $past(command_r[1]))
        else $error("mem accept wrong");
    a_fixed_zero:
    assert property ((command_r & ~`PCC_CMD_RW_MASK) == 16'h0000 &&
        (status_flags_r & 16'h37E7) == 16'h0000)
        else $error("fixed bit not zero");
    a_cap_list:
    assert property (status_flags_r[4]) else $error("cap list bit low");
    a_intx_status:
    assert property (status_flags_r[3] == $past(intx_pending))
        else $error("intx status wrong");
    a_parity_flag:
    assert property (poisoned_tlp_evt |=> status_flags_r[15] &&
        parity_action_r == $past(command_r[6]))
        else $error("poison handling wrong");
    a_serr_flag:
    assert property (err_msg_sent_evt && command_r[8] |=> status_flags_r[14])
        else $error("system error flag not set");
    a_w1c_clear:
    assert property (cfg_wr_en && cfg_dw_addr == `PCC_IDX_CMDSTAT &&
        cfg_byte_en[3] && cfg_wr_data[31] && !poisoned_tlp_evt |=>
        !status_flags_r[15]) else $error("write one did not clear");
endmodule // pcc_cfg_properties

bind pcc_cfg pcc_cfg_properties #(.EXT_CAP_VERSION(EXT_CAP_VERSION)) u_props
(
    .clk, .rst, .cfg_rd_en, .cfg_wr_en, .cfg_dw_addr, .cfg_byte_en,
    .cfg_wr_data, .cfg_rd_data_r, .io_req, .mem_req, .io_accept_r,
    .mem_accept_r, .poisoned_tlp_evt, .err_msg_sent_evt, .intx_pending,
    .parity_action_r, .command_r, .status_flags_r
);

// ===== tb/pcc_rc_model.sv
// far-side model: root complex issuing configuration reads and writes
module pcc_rc_model
(
    input  wire         clk,
    output logic        cfg_rd_en,
    output logic        cfg_wr_en,
    output logic [9:0]  cfg_dw_addr,
    output logic [3:0]  cfg_byte_en,
    output logic [31:0] cfg_wr_data,
    input  wire  [31:0] cfg_rd_data_r,
    input  wire         cfg_rd_valid_r,
    input  wire         cfg_wr_done_r
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {cfg_rd_en, cfg_wr_en, cfg_dw_addr, cfg_byte_en} = 16'h0000;
    initial cfg_wr_data = 32'h00000000;
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [9:0] a,
        input logic [3:0] be, input logic [31:0] wd,
        output logic [31:0] d, output logic ok);
        integer n;
        @(posedge clk);
        cfg_rd_en <= !w;
        cfg_wr_en <= w;
        cfg_dw_addr <= a;
        cfg_byte_en <= be;
        cfg_wr_data <= wd;
        @(posedge clk);
        {cfg_rd_en, cfg_wr_en} <= 2'b00;
        // released lines must not keep the last value
        cfg_dw_addr <= ~a;
        cfg_wr_data <= ~wd;
        #1;
        for (n = 0; n < 4 && (w ? cfg_wr_done_r : cfg_rd_valid_r) !== 1'b1;
            n++)
        begin
            @(posedge clk);
            #1;
        end
        d = cfg_rd_data_r;
        ok = (w ? cfg_wr_done_r : cfg_rd_valid_r) === 1'b1;
    endtask
endmodule // pcc_rc_model

// ===== tb/pcie_type0_config_command_status_bench.sv
// bench: configuration accesses and event handling of the config block
`include "pcc_map.vh"
module pcie_type0_config_command_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, ok;
    logic cfg_rd_en, cfg_wr_en, cfg_rd_valid_r, cfg_wr_done_r;
    logic [9:0] cfg_dw_addr;
    logic [3:0] cfg_byte_en;
    logic [31:0] cfg_wr_data, cfg_rd_data_r, d;
    logic id_load_en = 1'b0, intx_pending = 1'b0;
    logic [15:0] id_load_maker = 16'h1234, id_load_part = 16'h5678, c;
    logic io_req, mem_req, cpl_abort_evt, poisoned_tlp_evt;
    logic nonfatal_err_evt, fatal_err_evt, err_msg_sent_evt;
    logic io_accept_r, mem_accept_r, parity_action_r, intx_msg_en_r;
    logic err_nonfatal_req_r, err_fatal_req_r;
    logic [15:0] command_r, status_flags_r;
    integer failures = 0, n_compared = 0, i;
    always #10 clk = ~clk;
    pcc_rc_model u_rc (.clk, .cfg_rd_en, .cfg_wr_en, .cfg_dw_addr,
        .cfg_byte_en, .cfg_wr_data, .cfg_rd_data_r, .cfg_rd_valid_r,
        .cfg_wr_done_r);
    pcc_cfg DUT (.clk, .rst, .cfg_rd_en, .cfg_wr_en, .cfg_dw_addr,
        .cfg_byte_en, .cfg_wr_data, .cfg_rd_data_r, .cfg_rd_valid_r,
        .cfg_wr_done_r, .id_load_en, .id_load_maker, .id_load_part,
        .io_req, .mem_req, .io_accept_r, .mem_accept_r, .cpl_abort_evt,
        .poisoned_tlp_evt, .nonfatal_err_evt, .fatal_err_evt,
        .err_msg_sent_evt, .intx_pending, .parity_action_r,
        .err_nonfatal_req_r, .err_fatal_req_r, .intx_msg_en_r, .command_r,
        .status_flags_r);
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task xfer(input logic w, input logic [9:0] a, input logic [3:0] be,
        input logic [31:0] wd);
        u_rc.xfer(w, a, be, wd, d, ok);
        // a missing answer ends the run at once
        if (ok !== 1'b1)
        begin
            failures++;
            stop_test;
        end
    endtask
    task rd(input logic [9:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 4'h0, 32'h00000000);
        chk(nm, d, exp);
    endtask
    task fire(input logic [6:0] v);
        @(posedge clk);
        {mem_req, io_req, err_msg_sent_evt, fatal_err_evt, nonfatal_err_evt,
            poisoned_tlp_evt, cpl_abort_evt} <= v;
        @(posedge clk);
        {mem_req, io_req, err_msg_sent_evt, fatal_err_evt, nonfatal_err_evt,
            poisoned_tlp_evt, cpl_abort_evt} <= 7'h00;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {mem_req, io_req, err_msg_sent_evt, fatal_err_evt, nonfatal_err_evt,
            poisoned_tlp_evt, cpl_abort_evt} = 7'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(10'h000, {`PCC_PART_DFLT, `PCC_MAKER_DFLT}, "ident");
        rd(10'h001, 32'h00100000, "cmdstat");
        rd(`PCC_IDX_EXTCAP, {`PCC_EXT_NEXT_OFF, `PCC_EXT_CAP_VER,
            `PCC_EXT_CAP_ID}, "ext header");
        rd(10'h3FF, 32'h00000000, "unmapped");
        xfer(1'b1, 10'h000, 4'hF, 32'hFFFFFFFF);
        xfer(1'b1, 10'h001, 4'h0, 32'hFFFFFFFF);
        rd(10'h000, {`PCC_PART_DFLT, `PCC_MAKER_DFLT}, "ro ident");
        rd(10'h001, 32'h00100000, "no lanes");
        @(posedge clk);
        id_load_en <= 1'b1;
        @(posedge clk);
        id_load_en <= 1'b0;
        rd(10'h000, 32'h56781234, "ident load");
        $display("test reset and identity done");
        for (i = 0; i < 2; i++)
        begin
            c = i ? 16'h0543 : 16'h0000;
            // all ones also probes every hardwired bit
            xfer(1'b1, 10'h001, 4'hF, i ? 32'hFFFFFFFF : 32'h00000000);
            @(posedge clk);
            intx_pending <= 1'b1;
            fire(7'h7F);
            chk("io accept", io_accept_r, c[0]);
            chk("mem accept", mem_accept_r, c[1]);
            chk("parity action", parity_action_r, c[6]);
            chk("fatal req", err_fatal_req_r, c[8]);
            chk("nonfatal req", err_nonfatal_req_r, c[8]);
            chk("intx msg", intx_msg_en_r, !c[10]);
            chk("command out", command_r, c);
            chk("status out", status_flags_r,
                c[8] ? 16'hC818 : 16'h8818);
            rd(10'h001, {c[8] ? 16'hC818 : 16'h8818, c},
                "flags");
            xfer(1'b1, 10'h001, 4'h8, 32'h08000000);
            rd(10'h001, {c[8] ? 16'hC018 : 16'h8018, c}, "part clr");
            xfer(1'b1, 10'h001, 4'h8, 32'hFF000000);
            rd(10'h001, {16'h0018, c}, "all clr");
            $display("test events with command %h done", c);
        end
        @(posedge clk);
        intx_pending <= 1'b0;
        rd(10'h001, 32'h00100543, "intx idle");
        chk("intx msg idle", intx_msg_en_r, 1'b0);
        $display("test intx release done");
        stop_test;
    end
endmodule // pcie_type0_config_command_status_bench
